// ### src/isf_pkg.sv
// Package of the slave FIFO and status front end: register offsets,
// field positions, reset values and FIFO geometry.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package isf_pkg;

  // FIFO geometry
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam int LVL_W      = 5;

  // Register byte offsets
  localparam logic [5:0] OFS_DATA     = 6'h00;
  localparam logic [5:0] OFS_OPSTAT   = 6'h04;
  localparam logic [5:0] OFS_SLVADR   = 6'h08;
  localparam logic [5:0] OFS_CTRL     = 6'h0C;
  localparam logic [5:0] OFS_FLAGS    = 6'h10;
  localparam logic [5:0] OFS_IFLSEL   = 6'h14;
  localparam logic [5:0] OFS_IRQMASK  = 6'h18;
  localparam logic [5:0] OFS_IRQRAW   = 6'h1C;
  localparam logic [5:0] OFS_IRQMSKD  = 6'h20;
  localparam logic [5:0] OFS_IRQCLR   = 6'h24;
  localparam logic [5:0] OFS_DMACTL   = 6'h28;
  localparam logic [5:0] OFS_TSTDAT   = 6'h2C;
  localparam logic [5:0] OFS_PROCSTAT = 6'h30;
  localparam logic [5:0] OFS_HOSTCTL  = 6'h34;
  localparam logic [5:0] OFS_I2CDBG   = 6'h38;
  localparam logic [5:0] OFS_SPIDBG   = 6'h3C;

  // Data register fields
  localparam int DATA_RXLVL_LSB = 27;
  localparam int DATA_TXLVL_LSB = 22;
  localparam int DATA_RECEIVE_IN_PROGRESS    = 21;
  localparam int DATA_TXEMPTY   = 20;
  localparam int DATA_RXFULL    = 19;
  localparam int DATA_TXFULL    = 18;
  localparam int DATA_RXEMPTY   = 17;
  localparam int DATA_TRANSMIT_IN_PROGRESS    = 16;
  localparam int DATA_UNDERRUN  = 9;
  localparam int DATA_OVERRUN   = 8;

  // Operation status register error bits
  localparam int OPST_UNDERRUN = 1;
  localparam int OPST_OVERRUN  = 0;

  // Control register bits
  localparam int CTL_EN   = 0;
  localparam int CTL_SPI  = 1;
  localparam int CTL_I2C  = 2;
  localparam int CTL_BRK  = 7;
  localparam int CTL_HCE  = 12;
  localparam logic [31:0] CTL_WMASK = 32'h0000_131F;
  localparam logic [31:0] CTL_RST   = 32'h0000_0000;

  // Flag register level fields
  localparam int FLAG_RXLVL_LSB = 11;
  localparam int FLAG_TXLVL_LSB = 6;

  // Interrupt status bits
  localparam int IRQ_RXBYTE = 0;
  localparam int IRQ_TXBYTE = 1;
  localparam int IRQ_OVR    = 2;
  localparam int IRQ_UND    = 3;
  localparam int IRQ_W      = 4;

  // Byte handed to the master on an underrun
  localparam logic [7:0] UNDERRUN_FILL = 8'h00;

endpackage

// ### src/isf_fifo_if.sv
// Interface between a byte FIFO and its producer and consumer.
// Assumes one clock for all three parties.
`timescale 1ns/1ps
interface isf_fifo_if;
  import isf_pkg::*;
  logic             push;
  logic [7:0]       push_data;
  logic             pop;
  logic             flush;
  logic [7:0]       head;
  logic [LVL_W-1:0] level;
  logic             empty;
  logic             full;

  modport store (input push, push_data, pop, flush,
                 output head, level, empty, full);
  modport prod  (output push, push_data, flush,
                 input level, empty, full);
  modport cons  (output pop, input head, level, empty, full);
endinterface

// ### src/isf_fifo.sv
// Byte FIFO, sixteen deep, first word falls through to head.
// Assumes callers never push when full or pop when empty.
`timescale 1ns/1ps
module isf_fifo
  import isf_pkg::*;
(
  input  wire logic mclk,
  input  wire logic srst,
  isf_fifo_if.store f
);
  typedef struct packed {
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [LVL_W-1:0] cnt;
  } isf_fifo_st_t;

  isf_fifo_st_t     s_r;
  isf_fifo_st_t     s_nxt;
  logic [7:0]       mem [FIFO_DEPTH];
  logic             do_push;
  logic             do_pop;

  // Guard both sides so a misbehaving caller cannot corrupt the count
  assign do_push = f.push && !f.full && !f.flush;
  assign do_pop  = f.pop && !f.empty && !f.flush;

  always_comb begin
    s_nxt = s_r;
    if (f.flush) begin
      s_nxt = '0;
    end else begin
      if (do_push) s_nxt.wp = s_r.wp + 1'b1;
      if (do_pop)  s_nxt.rp = s_r.rp + 1'b1;
      if (do_push && !do_pop) s_nxt.cnt = s_r.cnt + 1'b1;
      if (do_pop && !do_push) s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) s_r <= '0;
    else      s_r <= s_nxt;
  end

  // Storage needs no reset; head is only meaningful while not empty
  always_ff @(posedge mclk) begin
    if (do_push) mem[s_r.wp] <= f.push_data;
  end

  assign f.head  = mem[s_r.rp];
  assign f.level = s_r.cnt;
  assign f.empty = (s_r.cnt == '0);
  assign f.full  = (s_r.cnt == LVL_W'(FIFO_DEPTH));
endmodule

// ### src/isf_serial_side.sv
// Serial-side byte router: master writes fill the receive FIFO, master
// reads drain the transmit FIFO, or go to the host registers.
// Assumes a serial engine that presents one byte access per strobe.
`timescale 1ns/1ps
module isf_serial_side
  import isf_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       enable,
  input  wire logic       flush_all,
  input  wire logic       route_host,
  input  wire logic       ser_wr,
  input  wire logic [7:0] ser_wr_data,
  input  wire logic       ser_rd,
  input  wire logic [7:0] proc_stat,
  isf_fifo_if.prod        rxq,
  isf_fifo_if.cons        txq,
  output logic [7:0]      ser_rd_data,
  output logic            ser_rd_valid,
  output logic            host_wr,
  output logic [7:0]      host_wr_data,
  output logic            ovr_ev,
  output logic            und_ev
);
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       hwr;
    logic [7:0] hdata;
    logic       ovr;
    logic       und;
  } isf_ser_st_t;

  isf_ser_st_t s_r;
  isf_ser_st_t s_nxt;

  // Every access while enabled is answered next cycle, so the bus is never held
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.hwr    = 1'b0;
    s_nxt.ovr    = 1'b0;
    s_nxt.und    = 1'b0;
    rxq.push      = 1'b0;
    rxq.push_data = ser_wr_data;
    rxq.flush     = flush_all;
    txq.pop       = 1'b0;
    if (enable && ser_wr) begin
      if (route_host) begin
        s_nxt.hwr   = 1'b1;
        s_nxt.hdata = ser_wr_data;
      end else if (rxq.full) begin
        s_nxt.ovr = 1'b1;                    // Byte dropped
      end else begin
        rxq.push = 1'b1;
      end
    end
    if (enable && ser_rd) begin
      s_nxt.rvalid = 1'b1;
      if (route_host) begin
        s_nxt.rdata = proc_stat;
      end else if (txq.empty) begin
        s_nxt.und   = 1'b1;
        s_nxt.rdata = UNDERRUN_FILL;
      end else begin
        txq.pop     = 1'b1;
        s_nxt.rdata = txq.head;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) s_r <= '0;
    else      s_r <= s_nxt;
  end

  assign ser_rd_data  = s_r.rdata;
  assign ser_rd_valid = s_r.rvalid;
  assign host_wr      = s_r.hwr;
  assign host_wr_data = s_r.hdata;
  assign ovr_ev       = s_r.ovr;
  assign und_ev       = s_r.und;
endmodule

// ### src/isf_top.sv
// Top of the slave FIFO and status front end: Avalon-MM register slave,
// two byte FIFOs, serial-side router, error flags and interrupt.
// Assumes the serial engine runs on mclk and strobes one byte at a time.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - No DMA request path; the four request bits read zero, writes ignored.
// - Software write of the data byte pushes it into the transmit FIFO.
// - Software read of the data byte pops the oldest receive FIFO byte.
// - Data register shows receive level at 31:27, transmit level at 26:22.
// - Bit 21 shows receive in progress, bit 16 transmit in progress.
// - Bit 20 shows transmit FIFO empty, bit 18 transmit FIFO full.
// - Bit 17 shows receive FIFO empty, bit 19 receive FIFO full.
// - Master reading an empty transmit FIFO sets underrun, bits 9 and 1.
// - Byte arriving into a full receive FIFO sets overrun, bits 8 and 0.
// - Error flags stay until software writes zero to status bit.
// - Seven-bit slave address register, reset zero, unused in SPI mode.
// - With host access, address bit 0 picks FIFOs or host registers.
// - Control bit 12 gates master access to host registers.
// - Slave only, seven-bit addressing, never stretches the clock.
module isf_top
  import isf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        ser_wr,
  input  wire logic [7:0]  ser_wr_data,
  input  wire logic        ser_rd,
  input  wire logic        ser_frame_active,
  input  wire logic        ser_frame_read,
  output logic [7:0]       ser_rd_data,
  output logic             ser_rd_valid,
  output logic             cfg_enable,
  output logic             cfg_spi_mode,
  output logic             cfg_i2c_mode,
  output logic [6:0]       cfg_slave_addr
);

  // Expand byte enables to a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Merge enabled write lanes into an old value under a field mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction

  typedef struct packed {
    logic        wait_n;
    logic [31:0] rdata;
    logic [31:0] ctrl;
    logic [6:0]  slave_addr_field;
    logic [7:0]  proc_stat;
    logic [7:0]  host_ctrl;
    logic        tx_underrun_error;
    logic        rx_overrun_error;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic        irq;
    logic        receive_in_progress;
    logic        transmit_in_progress;
  } isf_top_st_t;

  isf_top_st_t s_r;
  isf_top_st_t s_nxt;

  isf_fifo_if  txq ();
  isf_fifo_if  rxq ();

  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] wmask;
  logic [31:0] data_word;
  logic [31:0] opst_word;
  logic [31:0] flag_word;
  logic        route_host;
  logic        host_wr;
  logic [7:0]  host_wr_data;
  logic        ovr_ev;
  logic        und_ev;
  logic        tx_pop_d;
  logic        rx_push_d;
  logic        brk;

  // Transmit FIFO: software fills, serial side drains
  isf_fifo u_txq (
    .mclk (mclk),
    .srst (srst),
    .f    (txq.store)
  );

  // Receive FIFO: serial side fills, software drains
  isf_fifo u_rxq (
    .mclk (mclk),
    .srst (srst),
    .f    (rxq.store)
  );

  // Host-register routing needs the enable bit, I2C mode and address bit 0;
  // in SPI mode the address is ignored, so accesses always hit the FIFOs
  assign route_host = s_r.ctrl[CTL_HCE]
                    && s_r.ctrl[CTL_I2C]
                    && !s_r.ctrl[CTL_SPI]
                    && s_r.slave_addr_field[0];

  isf_serial_side u_ser (
    .mclk         (mclk),
    .srst         (srst),
    .enable       (s_r.ctrl[CTL_EN]),
    .flush_all    (brk),
    .route_host   (route_host),
    .ser_wr       (ser_wr),
    .ser_wr_data  (ser_wr_data),
    .ser_rd       (ser_rd),
    .proc_stat    (s_r.proc_stat),
    .rxq          (rxq.prod),
    .txq          (txq.cons),
    .ser_rd_data  (ser_rd_data),
    .ser_rd_valid (ser_rd_valid),
    .host_wr      (host_wr),
    .host_wr_data (host_wr_data),
    .ovr_ev       (ovr_ev),
    .und_ev       (und_ev)
  );

  // A request is taken once, in the cycle where waitrequest is still high;
  // the answer follows one cycle later with waitrequest low
  assign acc    = (avs_read || avs_write) && !s_r.wait_n;
  assign wr_acc = acc && avs_write;
  assign rd_acc = acc && avs_read;
  assign wmask  = be_mask(avs_byteenable);

  // Break clears both FIFOs in the cycle the control write is taken
  assign brk = wr_acc && (avs_address == OFS_CTRL)
             && avs_byteenable[0] && avs_writedata[CTL_BRK];

  // Software push into the transmit FIFO needs the low lane
  assign txq.push      = wr_acc && (avs_address == OFS_DATA)
                       && avs_byteenable[0] && !txq.full;
  assign txq.push_data = avs_writedata[7:0];
  assign txq.flush     = brk;

  // Software pop from the receive FIFO; an empty FIFO is not popped
  assign rxq.pop = rd_acc && (avs_address == OFS_DATA) && !rxq.empty;

  // Data register image: levels, busy, FIFO flags, errors and head byte
  always_comb begin
    data_word = '0;
    data_word[DATA_RXLVL_LSB +: LVL_W] = rxq.level;
    data_word[DATA_TXLVL_LSB +: LVL_W] = txq.level;
    data_word[DATA_RECEIVE_IN_PROGRESS]  = s_r.receive_in_progress;
    data_word[DATA_TRANSMIT_IN_PROGRESS]  = s_r.transmit_in_progress;
    data_word[DATA_TXEMPTY] = txq.empty;
    data_word[DATA_TXFULL]  = txq.full;
    data_word[DATA_RXEMPTY] = rxq.empty;
    data_word[DATA_RXFULL]  = rxq.full;
    data_word[DATA_UNDERRUN] = s_r.tx_underrun_error;
    data_word[DATA_OVERRUN]  = s_r.rx_overrun_error;
    if (!rxq.empty) begin
      data_word[7:0] = rxq.head;
    end
  end

  // Operation status image; the DMA request bits always read zero
  always_comb begin
    opst_word = '0;
    opst_word[OPST_UNDERRUN] = s_r.tx_underrun_error;
    opst_word[OPST_OVERRUN]  = s_r.rx_overrun_error;
  end

  // Flag register image carries the two FIFO levels
  always_comb begin
    flag_word = '0;
    flag_word[FLAG_RXLVL_LSB +: LVL_W] = rxq.level;
    flag_word[FLAG_TXLVL_LSB +: LVL_W] = txq.level;
  end

  // Byte movement seen by the interrupt logic, taken a cycle late so the
  // FIFO strobes stay short combinational paths
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_pop_d  <= 1'b0;
      rx_push_d <= 1'b0;
    end else begin
      tx_pop_d  <= txq.pop && !txq.empty;
      rx_push_d <= rxq.push && !rxq.full;
    end
  end

  // Next-state logic of the register file
  always_comb begin
    s_nxt = s_r;

    // Bus handshake: answer one cycle after the request is taken
    s_nxt.wait_n = acc;

    // Read mux; unmapped and write-only offsets read as zero
    if (rd_acc) begin
      case (avs_address)
        OFS_DATA:     s_nxt.rdata = data_word;
        OFS_OPSTAT:   s_nxt.rdata = opst_word;
        OFS_SLVADR:   s_nxt.rdata = {25'h0, s_r.slave_addr_field};
        OFS_CTRL:     s_nxt.rdata = s_r.ctrl;
        OFS_FLAGS:    s_nxt.rdata = flag_word;
        OFS_IRQMASK:  s_nxt.rdata = {28'h0, s_r.irq_mask};
        OFS_IRQRAW:   s_nxt.rdata = {28'h0, s_r.irq_stat};
        OFS_IRQMSKD:  s_nxt.rdata = {28'h0, s_r.irq_stat & s_r.irq_mask};
        OFS_PROCSTAT: s_nxt.rdata = {24'h0, s_r.proc_stat};
        OFS_HOSTCTL:  s_nxt.rdata = {24'h0, s_r.host_ctrl};
        default:      s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Plain read/write registers
    if (wr_acc) begin
      case (avs_address)
        OFS_SLVADR: begin
          s_nxt.slave_addr_field =
            7'(merge({25'h0, s_r.slave_addr_field}, avs_writedata,
                     wmask));
        end
        OFS_CTRL: begin
          // Break is a command, not a stored bit
          s_nxt.ctrl = merge(s_r.ctrl, avs_writedata,
                             wmask & CTL_WMASK & ~(32'h1 << CTL_BRK));
        end
        OFS_IRQMASK: begin
          s_nxt.irq_mask = IRQ_W'(merge({28'h0, s_r.irq_mask},
                                        avs_writedata, wmask));
        end
        OFS_PROCSTAT: begin
          s_nxt.proc_stat = 8'(merge({24'h0, s_r.proc_stat},
                                     avs_writedata, wmask));
        end
        OFS_HOSTCTL: begin
          s_nxt.host_ctrl = 8'(merge({24'h0, s_r.host_ctrl},
                                     avs_writedata, wmask));
        end
        default: begin
          // Status and clear are handled below, data pushes above; unused offsets do nothing
        end
      endcase
    end

    // A master write routed to the host register overrides software
    if (host_wr) begin
      s_nxt.host_ctrl = host_wr_data;
    end

    // Error flags: writing zero clears, a new event in the same cycle wins
    if (wr_acc && (avs_address == OFS_OPSTAT) && avs_byteenable[0]) begin
      if (!avs_writedata[OPST_UNDERRUN]) begin
        s_nxt.tx_underrun_error = 1'b0;
      end
      if (!avs_writedata[OPST_OVERRUN]) begin
        s_nxt.rx_overrun_error = 1'b0;
      end
    end
    if (und_ev) s_nxt.tx_underrun_error = 1'b1;
    if (ovr_ev) s_nxt.rx_overrun_error  = 1'b1;

    // Interrupt status: write one to clear, events set and win
    if (wr_acc && (avs_address == OFS_IRQCLR)) begin
      s_nxt.irq_stat = s_r.irq_stat
                     & ~(avs_writedata[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
    s_nxt.irq_stat[IRQ_RXBYTE] = s_nxt.irq_stat[IRQ_RXBYTE] | rx_push_d;
    s_nxt.irq_stat[IRQ_TXBYTE] = s_nxt.irq_stat[IRQ_TXBYTE] | tx_pop_d;
    s_nxt.irq_stat[IRQ_OVR]    = s_nxt.irq_stat[IRQ_OVR] | ovr_ev;
    s_nxt.irq_stat[IRQ_UND]    = s_nxt.irq_stat[IRQ_UND] | und_ev;

    // Level interrupt from the next-state status and mask, then registered
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

    // Busy follows the serial frame and its direction; idle clears both
    s_nxt.receive_in_progress  = ser_frame_active && !ser_frame_read;
    s_nxt.transmit_in_progress = ser_frame_active && ser_frame_read;
  end

  // Register the whole state; waitrequest rests high after reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r        <= '0;
      s_r.ctrl   <= CTL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state flops
  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = !s_r.wait_n;
  assign irq             = s_r.irq;
  assign cfg_enable      = s_r.ctrl[CTL_EN];
  assign cfg_spi_mode    = s_r.ctrl[CTL_SPI];
  assign cfg_i2c_mode    = s_r.ctrl[CTL_I2C];
  assign cfg_slave_addr  = s_r.slave_addr_field;
endmodule

// ### bench/isf_monitor.sv
// Checker of the slave front end, bound to isf_top.
// Assumes requests are held until waitrequest drops.
`timescale 1ns/1ps
module isf_monitor
  import isf_pkg::*;
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ser_rd,
  input wire logic        ser_rd_valid,
  input wire logic [6:0]  cfg_slave_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Request taken, and the answer edge of a read at one offset
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans(logic [5:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  property p_ans; s_req |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("bus not answered");
  // An answer only ever follows a taken request
  property p_cause;
    !avs_waitrequest |-> $past(avs_waitrequest);
  endproperty
  a_cause: assert property (p_cause) else $error("long answer");
  property p_cause_w;
    !avs_waitrequest |-> $past(avs_read || avs_write);
  endproperty
  a_cause_w: assert property (p_cause_w) else $error("stray answer");
  // Flags in one image must agree with the levels beside them
  property p_txe;
    s_ans(OFS_DATA) |-> avs_readdata[20] == (avs_readdata[26:22] == 5'h00);
  endproperty
  a_txe: assert property (p_txe) else $error("tx empty flag wrong");
  property p_txf;
    s_ans(OFS_DATA) |-> avs_readdata[18] == (avs_readdata[26:22] == 5'h10);
  endproperty
  a_txf: assert property (p_txf) else $error("tx full flag wrong");
  property p_rxe;
    s_ans(OFS_DATA) |-> avs_readdata[17] == (avs_readdata[31:27] == 5'h00);
  endproperty
  a_rxe: assert property (p_rxe) else $error("rx empty flag wrong");
  property p_dma; s_ans(OFS_OPSTAT) |-> avs_readdata[5:2] == 4'h0; endproperty
  a_dma: assert property (p_dma) else $error("request bits not zero");
  // Address write lands by the answer edge, data still held then
  property p_slv;
    s_req ##0 (avs_write && avs_address == OFS_SLVADR && avs_byteenable[0])
      |=> cfg_slave_addr == avs_writedata[6:0];
  endproperty
  a_slv: assert property (p_slv) else $error("address not held");
  property p_rdv; ser_rd_valid |-> $past(ser_rd); endproperty
  a_rdv: assert property (p_rdv) else $error("serial answer unasked");
endmodule

bind isf_top isf_monitor u_mon (.mclk, .srst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .ser_rd, .ser_rd_valid, .cfg_slave_addr);

// ### bench/isf_ser_master.sv
// Serial bus master model: byte strobes and frame levels.
// Assumes the slave takes one strobe per cycle and never stalls.
`timescale 1ns/1ps
module isf_ser_master (
  input  wire logic  mclk,
  output logic       ser_wr,
  output logic [7:0] ser_wr_data,
  output logic       ser_rd,
  output logic       ser_frame_active,
  output logic       ser_frame_read
);
  initial begin
    ser_wr = 1'b0;
    ser_wr_data = 8'hA5;
    ser_rd = 1'b0;
    ser_frame_active = 1'b0;
    ser_frame_read = 1'b0;
  end
  // Frame level and direction
  task automatic frame(input logic on, input logic rd);
    @(posedge mclk);
    ser_frame_active <= on;
    ser_frame_read   <= rd;
  endtask
  // Data line is scrambled after the strobe so stale bytes never match
  task automatic put(input logic [7:0] b);
    @(posedge mclk);
    ser_wr      <= 1'b1;
    ser_wr_data <= b;
    @(posedge mclk);
    ser_wr      <= 1'b0;
    ser_wr_data <= ~b;
  endtask
  // No wait for the slave: the clock is never held low
  task automatic get();
    @(posedge mclk);
    ser_rd <= 1'b1;
    @(posedge mclk);
    ser_rd <= 1'b0;
  endtask
endmodule

// ### bench/isf_top_tb.sv
// Self-checking bench of the slave front end.
// Assumes isf_top, its checker and the serial master model.
`timescale 1ns/1ps
module isf_top_tb;
  import isf_pkg::*;
  logic        mclk;
  logic        srst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        ser_wr;
  logic [7:0]  ser_wr_data;
  logic        ser_rd;
  logic        ser_frame_active;
  logic        ser_frame_read;
  logic [7:0]  ser_rd_data;
  logic        ser_rd_valid;
  logic [2:0]  cfg;
  int          n_mismatch;
  int          comparisons;
  logic [15:0] seed;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [7:0]  sq[$];
  logic [7:0]  b[16];

  isf_top DUT (.mclk, .srst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
    .avs_waitrequest, .irq, .ser_wr, .ser_wr_data, .ser_rd,
    .ser_frame_active, .ser_frame_read, .ser_rd_data, .ser_rd_valid,
    .cfg_enable(cfg[0]), .cfg_spi_mode(cfg[1]), .cfg_i2c_mode(cfg[2]),
    .cfg_slave_addr());
  isf_ser_master sm (.mclk, .ser_wr, .ser_wr_data, .ser_rd,
    .ser_frame_active, .ser_frame_read);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [5:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Read, noting the expected bits under a mask
  task automatic rd(input logic [5:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    mq.push_back(m);
    eq.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  // Interrupt is a register, so look once its edge has landed
  task automatic irq_is(input logic e);
    @(negedge mclk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // Oldest note is compared whenever an answer appears
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && eq.size() > 0)
      check("rdata", avs_readdata & mq.pop_front(), eq.pop_front());
    if (ser_rd_valid === 1'b1 && sq.size() > 0)
      check("ser_rd", {24'h0, ser_rd_data}, {24'h0, sq.pop_front()});
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end

  initial begin
    srst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    seed = 16'h71E0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    rd(OFS_DATA, 32'hFFFF_0300, 32'h0012_0000);
    rd(OFS_OPSTAT, 32'h0000_003F, 32'h0000_0000);
    rd(OFS_SLVADR, 32'h0000_007F, 32'h0000_0000);
    rd(OFS_I2CDBG, 32'hFFFF_FFFF, 32'h0000_0000);
    bus(OFS_CTRL, 1'b1, 32'h0000_0005);
    bus(OFS_SLVADR, 1'b1, 32'h0000_002A);
    rd(OFS_SLVADR, 32'h0000_007F, 32'h0000_002A);
    bus(OFS_IRQMASK, 1'b1, 32'h0000_0004);
    // Sixteen bytes fill the transmit FIFO; the seventeenth is dropped
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      if (i < 16) b[i] = seed[7:0];
      bus(OFS_DATA, 1'b1, {24'h0, seed[7:0]});
    end
    rd(OFS_DATA, 32'hFFDE_00FF, 32'h0406_0000);
    sm.frame(1'b1, 1'b1);
    rd(OFS_DATA, 32'h0021_0000, 32'h0001_0000);
    // Drain in order, then one read too many gets the filler
    for (int i = 0; i < 17; i++) begin
      sq.push_back(i < 16 ? b[i] : UNDERRUN_FILL);
      sm.get();
    end
    sm.frame(1'b0, 1'b0);
    rd(OFS_OPSTAT, 32'h0000_0003, 32'h0000_0002);
    rd(OFS_DATA, 32'h0010_0300, 32'h0010_0200);
    bus(OFS_OPSTAT, 1'b1, 32'h0000_0000);
    rd(OFS_DATA, 32'h0000_0300, 32'h0000_0000);
    sm.frame(1'b1, 1'b0);
    rd(OFS_DATA, 32'h0021_0000, 32'h0020_0000);
    // Seventeenth byte into a full receive FIFO overruns
    for (int i = 0; i < 17; i++) begin
      seed = lfsr(seed);
      if (i < 16) b[i] = seed[7:0];
      sm.put(seed[7:0]);
    end
    sm.frame(1'b0, 1'b0);
    rd(OFS_FLAGS, 32'h0000_FFC0, 32'h0000_8000);
    irq_is(1'b1);
    bus(OFS_IRQMASK, 1'b1, 32'h0000_0000);
    irq_is(1'b0);
    bus(OFS_IRQMASK, 1'b1, 32'h0000_0004);
    irq_is(1'b1);
    rd(OFS_OPSTAT, 32'h0000_0003, 32'h0000_0001);
    for (int i = 0; i < 16; i++)
      rd(OFS_DATA, 32'h0000_01FF, {24'h1, b[i]});
    rd(OFS_DATA, 32'hF802_01FF, 32'h0002_0100);
    bus(OFS_OPSTAT, 1'b1, 32'h0000_003C);
    rd(OFS_OPSTAT, 32'h0000_003F, 32'h0000_0000);
    bus(OFS_IRQCLR, 1'b1, 32'h0000_0004);
    irq_is(1'b0);
    // Host access: address bit 0 steers bytes to the host registers
    bus(OFS_CTRL, 1'b1, 32'h0000_1005);
    bus(OFS_SLVADR, 1'b1, 32'h0000_0001);
    seed = lfsr(seed);
    bus(OFS_PROCSTAT, 1'b1, {24'h0, seed[7:0]});
    sq.push_back(seed[7:0]);
    sm.get();
    sm.put(~seed[7:0]);
    rd(OFS_HOSTCTL, 32'h0000_00FF, {24'h0, ~seed[7:0]});
    rd(OFS_FLAGS, 32'h0000_FFC0, 32'h0000_0000);
    bus(OFS_CTRL, 1'b1, 32'h0000_0005);
    sm.put(seed[7:0]);
    rd(OFS_FLAGS, 32'h0000_FFC0, 32'h0000_0800);
    // SPI mode ignores the address, so the byte still goes to the FIFO
    bus(OFS_CTRL, 1'b1, 32'h0000_1007);
    check("cfg", {29'h0, cfg}, 32'h0000_0007);
    sm.put(seed[7:0]);
    rd(OFS_FLAGS, 32'h0000_FFC0, 32'h0000_1000);
    // Break empties the receive FIFO
    bus(OFS_CTRL, 1'b1, 32'h0000_0085);
    rd(OFS_DATA, 32'hF802_0000, 32'h0002_0000);
    repeat (2) @(posedge mclk);
    check("notes left", eq.size() + sq.size(), 32'h0000_0000);
    test_done();
  end
endmodule
